// ===== rtl/rxb_baseband.sv
// Behaviour
// - accepts receive ADC samples at twelve million samples per second and demodulates.
// - coherent chip-level O-QPSK demodulation, sync on preamble before delivering symbols.
// - gain updated every quarter symbol while no preamble detected.
// - after preamble detection gain frozen until packet ends or the delimiter search fails.
// - despread chips to 4-bit symbols, buffer, pass to MAC.
// - signal strength measured over each window of eight despread symbols (256 samples); a packet-end measurement restarts the window.
// - signal strength also measured when a received packet ends.
// - busy indicated when measured strength above energy threshold.
// - control interface lets software adjust LNA, receive filter, modulation.
module rxb_baseband #(
   parameter int unsigned SMP_W = 8,
   parameter int unsigned RSSI_W = 8,
   parameter int unsigned CAL_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic              adc_valid,
   input  wire logic [SMP_W-1:0]  adc_i,
   input  wire logic [SMP_W-1:0]  adc_q,
   input  wire logic              rx_enable,
   input  wire logic [RSSI_W-1:0] cca_threshold,
   input  wire logic [RSSI_W-1:0] agc_target,
   input  wire logic [CAL_W-1:0]  cal_lna_in,
   input  wire logic [CAL_W-1:0]  cal_filter_in,
   input  wire logic [CAL_W-1:0]  cal_mod_in,
   input  wire logic              cal_load,
   input  wire logic [4:0]        pkt_len,
   input  wire logic              sym_ready,
   output logic                   sym_valid,
   output logic [3:0]             sym_data,
   output logic                   pkt_start,
   output logic                   pkt_end,
   output logic [5:0]             rx_gain,
   output logic                   gain_frozen,
   output logic [RSSI_W-1:0]      rssi_value,
   output logic                   rssi_strobe,
   output logic                   cca_busy,
   output logic [CAL_W-1:0]       cal_lna,
   output logic [CAL_W-1:0]       cal_filter,
   output logic [CAL_W-1:0]       cal_mod
);
   initial begin
      if (SMP_W < 2 || RSSI_W < 4 || RSSI_W > 16 || CAL_W < 1)
         $error("rxb_baseband: unsupported widths");
   end

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      rxb_pkg::rxb_state_t st;
      logic [7:0]  qcnt;
      logic [4:0]  chip_cnt;
      logic [31:0] chips;
      logic        last_i;
      logic [3:0]  pre_cnt;
      logic [4:0]  body_cnt;
      logic [5:0]  gain;
      logic        frozen;
      logic [15:0] eacc;
      logic [2:0]  win_sym;
      logic [RSSI_W-1:0] rssi;
      logic        rssi_stb;
      logic        busy;
      logic [1:0]  bcnt;
      logic [3:0]  b0;
      logic [3:0]  b1;
      logic        pstart;
      logic        pend;
      logic [CAL_W-1:0] lna;
      logic [CAL_W-1:0] filt;
      logic [CAL_W-1:0] modc;
   } rxb_reg_t;

   rxb_reg_t s_q, s_d;

   // despread: closest of 16 spreading sequences by hamming distance
   function automatic logic [31:0] rxb_chipseq(input logic [3:0] s);
      logic [31:0] base;
      logic [31:0] r;
      base = 32'hD9C3522E;
      r = (base >> (4 * s[2:0])) | (base << (32 - 4 * s[2:0]));
      rxb_chipseq = s[3] ? (r ^ 32'hAAAAAAAA) : r;
   endfunction

   function automatic logic [3:0] rxb_despread(input logic [31:0] c);
      logic [5:0] best;
      logic [5:0] d;
      logic [3:0] sym;
      best = 6'h3F;
      sym = 4'h0;
      for (int k = 0; k < 16; k++) begin
         d = 6'($countones(c ^ rxb_chipseq(4'(k))));
         if (d < best) begin
            best = d;
            sym = 4'(k);
         end
      end
      rxb_despread = sym;
   endfunction

   function automatic logic [15:0] rxb_mag(input logic [SMP_W-1:0] v);
      rxb_mag = 16'(v[SMP_W-1] ? SMP_W'(~v + 1'b1) : v);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic        qtick, sym_done, buf_push, buf_pop, pkt_over;
   logic [3:0]  sym_now;
   logic [RSSI_W-1:0] meas;

   always_comb begin
      s_d = s_q;
      s_d.rssi_stb = 1'b0;
      s_d.pstart = 1'b0;
      s_d.pend = 1'b0;
      qtick = s_q.qcnt == 8'(rxb_pkg::QSYM_CYC - 1);
      s_d.qcnt = qtick ? 8'h00 : s_q.qcnt + 8'h01;
      // one sample per adc strobe; sign of I/Q gives chip decisions
      sym_done = 1'b0;
      if (adc_valid && rx_enable) begin
         // coherent O-QPSK, I and Q chips alternate with half-chip offset
         s_d.chips = {s_q.chips[30:0], s_q.last_i ? ~adc_q[SMP_W-1] : ~adc_i[SMP_W-1]};
         s_d.last_i = ~s_q.last_i;
         s_d.chip_cnt = s_q.chip_cnt + 5'h01;
         sym_done = s_q.chip_cnt == 5'h1F;
         s_d.eacc = s_q.eacc + rxb_mag(adc_i) + rxb_mag(adc_q);
      end
      // despread 32 chips into a symbol
      sym_now = rxb_despread(s_d.chips);
      buf_push = 1'b0;
      pkt_over = 1'b0;
      // preamble of zero symbols then delimiter before delivery
      case (s_q.st)
         rxb_pkg::RXB_HUNT: begin
            if (sym_done)
               s_d.pre_cnt = (sym_now == 4'h0) ? s_q.pre_cnt + 4'h1 : 4'h0;
            if (sym_done && sym_now == 4'h0 && s_q.pre_cnt == 4'(rxb_pkg::PREAMBLE_SYMS - 1))
               s_d.st = rxb_pkg::RXB_SFD;
         end
         rxb_pkg::RXB_SFD: begin
            if (sym_done && sym_now == rxb_pkg::SFD_LO)
               s_d.pre_cnt = 4'hF;
            else if (sym_done && s_q.pre_cnt == 4'hF && sym_now == rxb_pkg::SFD_HI) begin
               s_d.st = rxb_pkg::RXB_PAYLOAD;
               s_d.body_cnt = 5'h00;
               s_d.pstart = 1'b1;
            end else if (sym_done && sym_now != 4'h0) begin
               s_d.st = rxb_pkg::RXB_HUNT;
               s_d.pre_cnt = 4'h0;
            end
         end
         rxb_pkg::RXB_PAYLOAD: begin
            if (sym_done) begin
               buf_push = 1'b1;
               s_d.body_cnt = s_q.body_cnt + 5'h01;
               if (s_q.body_cnt == pkt_len - 5'h01)
                  pkt_over = 1'b1;
            end
         end
         default: s_d.st = rxb_pkg::RXB_HUNT;
      endcase
      if (!rx_enable)
         pkt_over = s_q.st != rxb_pkg::RXB_HUNT;
      if (pkt_over) begin
         s_d.st = rxb_pkg::RXB_HUNT;
         s_d.pre_cnt = 4'h0;
         s_d.pend = 1'b1;
      end
      // gain steps each quarter symbol until preamble seen
      if (s_q.st == rxb_pkg::RXB_HUNT && qtick && !s_q.frozen) begin
         if (rxb_mag(adc_i) > 16'(agc_target) && s_q.gain != 6'h00)
            s_d.gain = s_q.gain - 6'h01;
         else if (rxb_mag(adc_i) < 16'(agc_target) && s_q.gain != 6'h3F)
            s_d.gain = s_q.gain + 6'h01;
      end
      // freeze from preamble until packet end or return to hunt from delimiter search
      if (s_q.st == rxb_pkg::RXB_HUNT && s_d.st == rxb_pkg::RXB_SFD)
         s_d.frozen = 1'b1;
      if (pkt_over || (s_q.st == rxb_pkg::RXB_SFD && s_d.st == rxb_pkg::RXB_HUNT))
         s_d.frozen = 1'b0;
      meas = s_d.eacc[15 -: RSSI_W];
      if (sym_done)
         s_d.win_sym = s_q.win_sym + 3'h1;
      if ((sym_done && s_q.win_sym == 3'h7) || s_q.pend) begin
         s_d.rssi = meas;
         s_d.rssi_stb = 1'b1;
         s_d.eacc = 16'h0000;
         s_d.win_sym = 3'h0;
         // equal counts as clear, refreshed per measurement
         s_d.busy = meas > cca_threshold;
      end
      // two-entry buffer; push while full would drop, so MAC must keep up
      buf_pop = sym_valid && sym_ready;
      case ({buf_push && s_q.bcnt != 2'h2, buf_pop})
         2'b10: begin
            if (s_q.bcnt == 2'h0) s_d.b0 = sym_now;
            else s_d.b1 = sym_now;
            s_d.bcnt = s_q.bcnt + 2'h1;
         end
         2'b01: begin
            s_d.b0 = s_q.b1;
            s_d.bcnt = s_q.bcnt - 2'h1;
         end
         2'b11: begin
            if (s_q.bcnt == 2'h1) s_d.b0 = sym_now;
            else begin
               s_d.b0 = s_q.b1;
               s_d.b1 = sym_now;
            end
         end
         default: ;
      endcase
      if (cal_load) begin
         s_d.lna = cal_lna_in;
         s_d.filt = cal_filter_in;
         s_d.modc = cal_mod_in;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.st <= rxb_pkg::RXB_HUNT;
         s_q.gain <= rxb_pkg::GAIN_RST;
         s_q.last_i <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // MAC pops one symbol per handshake
   assign sym_valid   = s_q.bcnt != 2'h0;
   assign sym_data    = s_q.b0;
   assign pkt_start   = s_q.pstart;
   assign pkt_end     = s_q.pend;
   assign rx_gain     = s_q.gain;
   assign gain_frozen = s_q.frozen;
   assign rssi_value  = s_q.rssi;
   assign rssi_strobe = s_q.rssi_stb;
   assign cca_busy    = s_q.busy;
   assign cal_lna     = s_q.lna;
   assign cal_filter  = s_q.filt;
   assign cal_mod     = s_q.modc;

   ////////////////////////////////////////////////////////////////////////
   property p_gain_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      s_q.frozen && $past(s_q.frozen) |-> rx_gain == $past(rx_gain);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain moved while frozen");

   property p_gain_qsym;
      @(posedge ref_clk) disable iff (!rst_b)
      rx_gain != $past(rx_gain) |-> $past(qtick) && !$past(s_q.frozen);
   endproperty
   a_gain_qsym: assert property (p_gain_qsym) else $error("gain change off quarter symbol");

   property p_cca;
      @(posedge ref_clk) disable iff (!rst_b)
      rssi_strobe |-> cca_busy == (rssi_value > $past(cca_threshold));
   endproperty
   a_cca: assert property (p_cca) else $error("busy does not match rssi");

   property p_end_rssi;
      @(posedge ref_clk) disable iff (!rst_b)
      pkt_end |=> rssi_strobe;
   endproperty
   a_end_rssi: assert property (p_end_rssi) else $error("no rssi at packet end");

   property p_sym_stable;
      @(posedge ref_clk) disable iff (!rst_b)
      sym_valid && !sym_ready |=> sym_valid && $stable(sym_data);
   endproperty
   a_sym_stable: assert property (p_sym_stable) else $error("symbol dropped under stall");

   property p_start_sync;
      @(posedge ref_clk) disable iff (!rst_b)
      pkt_start |-> gain_frozen;
   endproperty
   a_start_sync: assert property (p_start_sync) else $error("start without preamble lock");

   property p_cal;
      @(posedge ref_clk) disable iff (!rst_b)
      cal_load |=> cal_lna == $past(cal_lna_in) && cal_mod == $past(cal_mod_in);
   endproperty
   a_cal: assert property (p_cal) else $error("trim not loaded");

   property p_busy_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      !rssi_strobe |-> $stable(cca_busy);
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy changed without measurement");
endmodule

// ===== rtl/rxb_pkg.sv
package rxb_pkg;
   // 802.15.4 2.4 GHz O-QPSK timing
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned SYM_RATE_HZ    = 62_500;
   // symbol period 16000 ns, quarter symbol 4000 ns
   localparam int unsigned SYM_NS         = 16_000;
   localparam int unsigned CLK_NS         = 40;
   localparam int unsigned QSYM_CYC       = (SYM_NS / 4) / CLK_NS;
   localparam int unsigned ADC_MSPS       = 12;
   localparam int unsigned CHIPS_PER_SYM  = 32;
   localparam int unsigned RSSI_WIN_SYMS  = 8;
   localparam int unsigned PREAMBLE_SYMS  = 8;
   localparam logic [3:0]  SFD_LO         = 4'h7;
   localparam logic [3:0]  SFD_HI         = 4'hA;
   localparam int unsigned GAIN_W         = 6;
   localparam logic [5:0]  GAIN_RST       = 6'h20;
   localparam int unsigned MAX_SYM_ERR    = 8;
   typedef enum logic [1:0] {RXB_HUNT, RXB_SFD, RXB_PAYLOAD} rxb_state_t;
endpackage

// ===== sim/rxb_mac_model.sv
module rxb_mac_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       sym_valid,
   input  wire logic [3:0] sym_data,
   input  wire logic       stall,
   output logic            sym_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] rx_q[$];
   // stall lets the bench prove no word is lost
   assign sym_ready = ~stall;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_q.delete();
      end else if (sym_valid && sym_ready) begin
         rx_q.push_back(sym_data);
      end
   end
endmodule

// ===== sim/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk, rst_b, adc_valid, rx_enable, cal_load, sym_ready, stall, pend_q;
   logic [7:0] adc_i, adc_q, cca_threshold, agc_target, cal_lna_in, cal_filter_in, cal_mod_in;
   logic [7:0] rssi_value, cal_lna, cal_filter, cal_mod;
   logic [4:0] pkt_len;
   logic [3:0] sym_data;
   logic [5:0] rx_gain;
   logic       sym_valid, pkt_start, pkt_end, gain_frozen, rssi_strobe, cca_busy;
   logic [7:0] w_rssi[4];
   logic       w_busy[4];
   int         w_at[4];
   int         err_total, cmp_count, cyc, win_n, st_n;

   rxb_baseband dut (.ref_clk(ref_clk), .rst_b(rst_b), .adc_valid(adc_valid), .adc_i(adc_i), .adc_q(adc_q),
      .rx_enable(rx_enable), .cca_threshold(cca_threshold), .agc_target(agc_target), .cal_lna_in(cal_lna_in),
      .cal_filter_in(cal_filter_in), .cal_mod_in(cal_mod_in), .cal_load(cal_load), .pkt_len(pkt_len),
      .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_data(sym_data), .pkt_start(pkt_start),
      .pkt_end(pkt_end), .rx_gain(rx_gain), .gain_frozen(gain_frozen), .rssi_value(rssi_value),
      .rssi_strobe(rssi_strobe), .cca_busy(cca_busy), .cal_lna(cal_lna), .cal_filter(cal_filter),
      .cal_mod(cal_mod));
   rxb_mac_model mac (.ref_clk(ref_clk), .rst_b(rst_b), .sym_valid(sym_valid), .sym_data(sym_data),
      .stall(stall), .sym_ready(sym_ready));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] chips(input logic [3:0] s);
      logic [31:0] b;
      b = 32'hD9C3522E;
      b = (b >> (4 * s[2:0])) | (b << (32 - 4 * s[2:0]));
      return s[3] ? (b ^ 32'hAAAAAAAA) : b;
   endfunction

   // same value on both rails, so either rail choice decodes
   task automatic send_sym(input logic [3:0] s);
      logic [31:0] c;
      c = chips(s);
      for (int k = 31; k >= 0; k--) begin
         @(posedge ref_clk);
         adc_valid <= 1'b1;
         adc_i <= c[k] ? 8'h40 : 8'hC0;
         adc_q <= c[k] ? 8'h40 : 8'hC0;
      end
   endtask
////////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cyc++;
      pend_q <= pkt_end;
      if (pkt_start) begin
         st_n++;
      end
      if (pend_q) begin
         chk("end_strobe", rssi_strobe, 1);
      end
      if (rssi_strobe && !pend_q && win_n < 4) begin
         w_rssi[win_n] = rssi_value;
         w_busy[win_n] = cca_busy;
         w_at[win_n] = cyc;
         win_n++;
      end
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      chk("sym_valid", sym_valid, 0);
      chk("rx_gain", rx_gain, 6'h20);
      chk("gain_frozen", gain_frozen, 0);
      chk("cca_busy", cca_busy, 0);
      chk("cal_mod", cal_mod, 0);
      $display("test reset done");
   endtask

   task automatic test_cal();
      cal_lna_in <= 8'h5A;
      cal_filter_in <= 8'hA5;
      cal_mod_in <= 8'h3C;
      cal_load <= 1'b1;
      @(posedge ref_clk);
      cal_load <= 1'b0;
      @(posedge ref_clk);
      chk("cal_lna", cal_lna, 8'h5A);
      chk("cal_filter", cal_filter, 8'hA5);
      chk("cal_mod", cal_mod, 8'h3C);
      $display("test cal done");
   endtask

   task automatic test_packet();
      logic [5:0] g;
      logic [3:0] pay[4];
      int         i;
      pay = '{4'h3, 4'h8, 4'hF, 4'h0};
      g = rx_gain;
      for (i = 0; i < 4; i++) send_sym(4'h5);
      chk("gain_moved", rx_gain !== g, 1);
      chk("frozen_hunt", gain_frozen, 0);
      for (i = 0; i < 8; i++) send_sym(4'h0);
      send_sym(4'h7);
      send_sym(4'hA);
      // first window already judged at the equal threshold
      cca_threshold <= 8'h7F;
      chk("frozen_pre", gain_frozen, 1);
      g = rx_gain;
      stall <= 1'b1;
      send_sym(pay[0]);
      send_sym(pay[1]);
      stall <= 1'b0;
      send_sym(pay[2]);
      send_sym(pay[3]);
      @(posedge ref_clk);
      adc_valid <= 1'b0;
      chk("gain_hold", rx_gain, g);
      for (i = 0; i < 200 && pkt_end !== 1'b1; i++) @(posedge ref_clk);
      if (pkt_end !== 1'b1) begin
         err_total++;
         give_verdict();
      end
      repeat (4) @(posedge ref_clk);
      chk("frozen_end", gain_frozen, 0);
      chk("starts", st_n, 1);
      chk("sym_count", mac.rx_q.size(), 4);
      for (i = 0; i < 4; i++) chk("sym_data", mac.rx_q[i], pay[i]);
      chk("windows", win_n, 2);
      chk("win_gap", w_at[1] - w_at[0], 256);
      chk("win_rssi", w_rssi[0], 8'h80);
      chk("equal_clear", w_busy[0], 0);
      chk("above_busy", w_busy[1], 1);
      chk("end_rssi", rssi_value, 8'h20);
      chk("end_clear", cca_busy, 0);
      $display("test packet done");
   endtask

   task automatic test_abort();
      int i;
      for (i = 0; i < 8; i++) send_sym(4'h0);
      send_sym(4'h7);
      send_sym(4'hA);
      send_sym(4'hC);
      @(posedge ref_clk);
      adc_valid <= 1'b0;
      // dropping enable mid-payload must close the packet
      rx_enable <= 1'b0;
      for (i = 0; i < 8 && pkt_end !== 1'b1; i++) @(posedge ref_clk);
      if (pkt_end !== 1'b1) begin
         err_total++;
         give_verdict();
      end
      @(posedge ref_clk);
      rx_enable <= 1'b1;
      chk("abort_unfreeze", gain_frozen, 0);
      chk("abort_rssi", rssi_value, 8'h30);
      chk("abort_clear", cca_busy, 0);
      chk("abort_starts", st_n, 2);
      chk("abort_windows", win_n, 3);
      chk("abort_count", mac.rx_q.size(), 5);
      chk("abort_data", mac.rx_q[4], 4'hC);
      $display("test abort done");
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      cmp_count = 0;
      cyc = 0;
      win_n = 0;
      st_n = 0;
      rst_b = 1'b0;
      adc_valid = 1'b0;
      adc_i = 8'h00;
      adc_q = 8'h00;
      rx_enable = 1'b1;
      cca_threshold = 8'h80;
      agc_target = 8'h10;
      cal_lna_in = 8'h00;
      cal_filter_in = 8'h00;
      cal_mod_in = 8'h00;
      cal_load = 1'b0;
      pkt_len = 5'h04;
      stall = 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      test_reset();
      test_cal();
      test_packet();
      test_abort();
      give_verdict();
   end
endmodule
